// File: rtl/sfx_synth.sv
// sound effect synthesizer with pwm audio output
// assumes decoded register accesses arrive synchronously, one per cycle at most,
// and that pb_sample is the already volume-scaled signed playback sample
//
// Overview of operation
// - mono audio as pwm on one pin
// - pin mixes synthesizer and sample playback
// - sine and beep effects built from internal rom wave table, square and triangle computed
// - play reads 1 while sounding, else 0
// - some effects sound until retriggered
// - new trigger abandons current effect immediately
// - code 0 is silence and stops effects
// - separate effect volume register scales loudness
// - 16-bit select, low byte is code
// - high byte is semitone note number when pitched
// - note zero gives middle c
// - unpitched effects ignore the high byte
`timescale 1ns/1ps
`include "sfx_consts.svh"

module sfx_synth #(
    parameter int CLICK_CYCLES = `SFX_CLICK_CYCLES,
    parameter int BEEP_CYCLES  = `SFX_BEEP_CYCLES
) (
    input  wire logic                 clk,
    input  wire logic                 rst,
    input  wire sfx_pkg::sfx_reg_req_t reg_req,
    output logic [15:0]               reg_rdata,
    input  wire logic signed [7:0]    pb_sample,
    output logic                      audio_pwm
);

    // ==========================================================
    // registers
    logic [15:0]        sound_sel;
    logic [7:0]         vol_sound;
    logic               playing;
    logic [7:0]         act_code;
    logic [7:0]         act_note;
    logic [31:0]        phase;
    logic [31:0]        dur_cnt;
    logic signed [7:0]  scaled;
    logic [7:0]         pwm_level;
    logic [7:0]         pwm_cnt;
    logic               trigger;

    assign trigger = reg_req.wr && reg_req.addr == `SFX_IDX_PLAY && reg_req.data[0];

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            sound_sel <= `SFX_RST_SOUND;
            vol_sound <= `SFX_RST_VOL;
        end
        else if (reg_req.wr && reg_req.addr == `SFX_IDX_SOUND)
        begin
            sound_sel <= reg_req.data;
        end
        else if (reg_req.wr && reg_req.addr == `SFX_IDX_VOL)
        begin
            vol_sound <= reg_req.data[7:0];
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= 16'h0000;
        end
        else
        begin
            unique case (reg_req.addr)
                `SFX_IDX_SOUND: reg_rdata <= sound_sel;
                `SFX_IDX_PLAY:  reg_rdata <= {15'h0000, playing};
                `SFX_IDX_VOL:   reg_rdata <= {8'h00, vol_sound};
                default:        reg_rdata <= 16'h0000;
            endcase
        end
    end

    // ==========================================================
    // effect decode
    sfx_pkg::sfx_wave_t wave;
    logic               pitched;
    logic               finite;
    logic [31:0]        length;
    logic [3:0]         fix_semi;
    logic [3:0]         fix_shift;

    always_comb
    begin
        wave      = sfx_pkg::SFX_WAVE_NONE;
        pitched   = 1'b0;
        finite    = 1'b0;
        length    = 32'h0000_0000;
        fix_semi  = 4'h0;
        fix_shift = 4'h0;
        unique case (act_code)
            `SFX_CODE_SINE:     begin wave = sfx_pkg::SFX_WAVE_SINE;     pitched = 1'b1; end
            `SFX_CODE_SQUARE:   begin wave = sfx_pkg::SFX_WAVE_SQUARE;   pitched = 1'b1; end
            `SFX_CODE_TRIANGLE: begin wave = sfx_pkg::SFX_WAVE_TRIANGLE; pitched = 1'b1; end
            `SFX_CODE_CLICK:
            begin
                wave      = sfx_pkg::SFX_WAVE_SQUARE;
                finite    = 1'b1;
                length    = 32'(CLICK_CYCLES);
                fix_shift = `SFX_CLICK_SHIFT;
            end
            `SFX_CODE_BEEP:
            begin
                wave      = sfx_pkg::SFX_WAVE_SINE;
                finite    = 1'b1;
                length    = 32'(BEEP_CYCLES);
                fix_semi  = `SFX_BEEP_SEMI;
                fix_shift = `SFX_BEEP_SHIFT;
            end
            default:            wave = sfx_pkg::SFX_WAVE_NONE;
        endcase
    end

    // ==========================================================
    // pitch: semitone table shifted by octave
    logic [15:0] semi_rom [`SFX_SEMI_COUNT];
    logic signed [7:0] sine_rom [`SFX_SINE_COUNT];

    generate
        for (genvar i = 0; i < `SFX_SEMI_COUNT; i++)
        begin : g_semi
            localparam logic [16*`SFX_SEMI_COUNT-1:0] SEMI = `SFX_SEMI_TABLE;
            assign semi_rom[i] = SEMI[16*i +: 16];
        end
        for (genvar j = 0; j < `SFX_SINE_COUNT; j++)
        begin : g_sine
            localparam logic [8*`SFX_SINE_COUNT-1:0] SINE = `SFX_SINE_TABLE;
            assign sine_rom[j] = SINE[8*j +: 8];
        end
    endgenerate

    logic [3:0]  semi;
    logic [3:0]  shift;
    logic [4:0]  oct;
    logic [31:0] inc;

    always_comb
    begin
        oct = 5'(act_note / 8'(`SFX_SEMI_COUNT));
        if (pitched)
        begin
            semi  = 4'(act_note % 8'(`SFX_SEMI_COUNT));
            shift = (oct > 5'(`SFX_OCT_MAX)) ? `SFX_OCT_MAX : oct[3:0];
        end
        else
        begin
            semi  = fix_semi;
            shift = fix_shift;
        end
        inc = {16'h0000, semi_rom[semi]} << shift;
    end

    // ==========================================================
    // sequencing
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            playing  <= 1'b0;
            act_code <= `SFX_CODE_SILENCE;
            act_note <= 8'h00;
            phase    <= 32'h0000_0000;
            dur_cnt  <= 32'h0000_0000;
        end
        else if (trigger)
        begin
            act_code <= sound_sel[`SFX_CODE_MSB:0];
            act_note <= sound_sel[`SFX_NOTE_MSB:`SFX_NOTE_LSB];
            playing  <= sound_sel[`SFX_CODE_MSB:0] != `SFX_CODE_SILENCE;
            phase    <= 32'h0000_0000;
            dur_cnt  <= 32'h0000_0000;
        end
        else if (playing)
        begin
            phase   <= phase + inc;
            dur_cnt <= dur_cnt + 32'h0000_0001;
            if (wave == sfx_pkg::SFX_WAVE_NONE || (finite && dur_cnt + 32'h0000_0001 >= length))
            begin
                playing  <= 1'b0;
                act_code <= `SFX_CODE_SILENCE;
            end
        end
    end

    // ==========================================================
    // wave, volume, mix, pwm
    logic signed [7:0]  raw;
    logic signed [16:0] prod;
    logic signed [8:0]  mix;

    always_comb
    begin
        unique case (wave)
            sfx_pkg::SFX_WAVE_SINE:     raw = sine_rom[phase[31:28]];
            sfx_pkg::SFX_WAVE_SQUARE:   raw = phase[31] ? `SFX_SQ_LOW : `SFX_SQ_HIGH;
            sfx_pkg::SFX_WAVE_TRIANGLE: raw = phase[31] ? 8'(8'h7f - {phase[30:24], 1'b0})
                                                        : 8'(8'h81 + {phase[30:24], 1'b0});
            sfx_pkg::SFX_WAVE_NONE:     raw = 8'h00;
        endcase
        if (!playing)
        begin
            raw = 8'h00;
        end
        prod = raw * $signed({1'b0, vol_sound});
        mix  = 9'(scaled) + 9'(pb_sample);
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            scaled    <= 8'h00;
            pwm_level <= `SFX_PWM_OFFSET;
            pwm_cnt   <= 8'h00;
            audio_pwm <= 1'b0;
        end
        else
        begin
            scaled  <= prod[15:8];
            pwm_cnt <= pwm_cnt + 8'h01;
            if (mix > $signed(`SFX_PCM_MAX))
            begin
                pwm_level <= 8'h7f ^ `SFX_PWM_OFFSET;
            end
            else if (mix < $signed(`SFX_PCM_MIN))
            begin
                pwm_level <= 8'h80 ^ `SFX_PWM_OFFSET;
            end
            else
            begin
                pwm_level <= mix[7:0] ^ `SFX_PWM_OFFSET;
            end
            audio_pwm <= pwm_cnt < pwm_level;
        end
    end

    // ==========================================================
    // assertions
    AST_TRIG_STARTS: assert property (@(posedge clk) disable iff (rst)
        trigger && sound_sel[7:0] == `SFX_CODE_SINE |=> playing && act_code == `SFX_CODE_SINE)
        else $error("trigger did not start the effect");
    AST_SILENCE_STOPS: assert property (@(posedge clk) disable iff (rst)
        trigger && sound_sel[7:0] == `SFX_CODE_SILENCE |=>
        !playing ##1 ($past(reg_req.addr) != `SFX_IDX_PLAY || reg_rdata == 16'h0000))
        else $error("silence did not stop playback");
    AST_PLAY_READBACK: assert property (@(posedge clk) disable iff (rst)
        reg_req.addr == `SFX_IDX_PLAY |=> reg_rdata == {15'h0000, $past(playing)})
        else $error("play readback wrong");
    AST_CONT_HOLDS: assert property (@(posedge clk) disable iff (rst)
        playing && act_code == `SFX_CODE_SQUARE && !trigger |=> playing)
        else $error("continuous effect ended by itself");
    AST_RETRIGGER: assert property (@(posedge clk) disable iff (rst)
        playing && trigger |=> phase == 32'h0000_0000 && act_code == $past(sound_sel[7:0]))
        else $error("retrigger did not restart");
    AST_VOL_ZERO: assert property (@(posedge clk) disable iff (rst)
        vol_sound == 8'h00 |=> scaled == 8'h00)
        else $error("zero volume not silent");
    AST_NOTE_ZERO: assert property (@(posedge clk) disable iff (rst)
        playing && pitched && act_note == 8'h00 |-> inc == 32'h0000_57ca)
        else $error("note zero is not middle c");
    AST_UNPITCHED: assert property (@(posedge clk) disable iff (rst)
        playing && act_code == `SFX_CODE_CLICK |-> inc == {16'h0000, semi_rom[0]} << `SFX_CLICK_SHIFT)
        else $error("unpitched effect used the note");
    AST_FINITE_ENDS: assert property (@(posedge clk) disable iff (rst)
        playing && finite && !trigger && dur_cnt + 32'h0000_0001 >= length |=> !playing)
        else $error("finite effect did not end");
    AST_SILENT_IDLE: assert property (@(posedge clk) disable iff (rst)
        !playing ##1 !playing |-> scaled == 8'h00)
        else $error("idle synthesizer not silent");

    COV_PITCHED: cover property (@(posedge clk) disable iff (rst) trigger ##1 playing && pitched);
    COV_CLICK_END: cover property (@(posedge clk) disable iff (rst) playing && act_code == `SFX_CODE_CLICK ##1 !playing);
    COV_RETRIG: cover property (@(posedge clk) disable iff (rst) playing && trigger);

endmodule : sfx_synth

// File: rtl/sfx_consts.svh
// constants for the sound effect synthesizer: register indices, codes, timing, tables
// assumes a 50 mhz core clock and decoded register accesses from the serial host port
`ifndef SFX_CONSTS_SVH
`define SFX_CONSTS_SVH

// register indices on the decoded host register port
`define SFX_IDX_SOUND      2'h0
`define SFX_IDX_PLAY       2'h1
`define SFX_IDX_VOL        2'h2
`define SFX_RST_SOUND      16'h0000
`define SFX_RST_VOL        8'hff

// effect select fields
`define SFX_CODE_MSB       7
`define SFX_NOTE_LSB       8
`define SFX_NOTE_MSB       15

// effect codes
`define SFX_CODE_SILENCE   8'h00
`define SFX_CODE_SINE      8'h01
`define SFX_CODE_SQUARE    8'h02
`define SFX_CODE_TRIANGLE  8'h03
`define SFX_CODE_CLICK     8'h10
`define SFX_CODE_BEEP      8'h11

// timing
`define SFX_CLK_KHZ        50000
`define SFX_CLICK_MS       2
`define SFX_BEEP_MS        100
`define SFX_CLICK_CYCLES   (`SFX_CLICK_MS * `SFX_CLK_KHZ)
`define SFX_BEEP_CYCLES    (`SFX_BEEP_MS * `SFX_CLK_KHZ)

// pitch: phase increments per clock for the 12 semitones starting at middle c
`define SFX_SEMI_TABLE     {16'ha5b7, 16'h9c6a, 16'h93a3, 16'h8b5a, 16'h8388, 16'h7c26, \
                            16'h752f, 16'h6e9b, 16'h6866, 16'h628a, 16'h5d02, 16'h57ca}
`define SFX_SEMI_COUNT     12
`define SFX_OCT_MAX        4'h7
`define SFX_CLICK_SHIFT    4'h4
`define SFX_BEEP_SEMI      4'h9
`define SFX_BEEP_SHIFT     4'h1

// wave table: one period of a signed sine in 16 entries
`define SFX_SINE_TABLE     {8'hcf, 8'ha6, 8'h8b, 8'h81, 8'h8b, 8'ha6, 8'hcf, 8'h00, \
                            8'h31, 8'h5a, 8'h75, 8'h7f, 8'h75, 8'h5a, 8'h31, 8'h00}
`define SFX_SINE_COUNT     16
`define SFX_SQ_HIGH        8'h60
`define SFX_SQ_LOW         8'ha0
`define SFX_PCM_MAX        9'h07f
`define SFX_PCM_MIN        9'h180
`define SFX_PWM_OFFSET     8'h80

`endif

// File: rtl/sfx_pkg.sv
// types shared by the sound effect synthesizer
// assumes sfx_consts.svh supplies all numeric constants
package sfx_pkg;

    typedef struct packed {
        logic        wr;
        logic [1:0]  addr;
        logic [15:0] data;
    } sfx_reg_req_t;

    typedef enum logic [1:0] {
        SFX_WAVE_SINE     = 2'b00,
        SFX_WAVE_SQUARE   = 2'b01,
        SFX_WAVE_TRIANGLE = 2'b10,
        SFX_WAVE_NONE     = 2'b11
    } sfx_wave_t;

endpackage : sfx_pkg

// File: verif/sfx_lpf_model.sv
// filter and amplifier model: sliding 256-clock average of the pwm audio pin
// assumes a pwm period of 256 clocks, so a steady level yields an exact count
`timescale 1ns/1ps

module sfx_lpf_model (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  pwm_in,
    output logic [8:0] level
);
    logic [255:0] hist;

    // ====================
    // averaging window
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            hist  <= '0;
            level <= 9'h000;
        end
        else
        begin
            hist  <= {hist[254:0], pwm_in};
            level <= level + {8'h00, pwm_in} - {8'h00, hist[255]};
        end
    end
endmodule : sfx_lpf_model

// File: verif/sfx_synth_tb.sv
// self-checking bench for the sound effect synthesizer
// assumes sfx_consts.svh and sfx_pkg are compiled first; filter model on the audio pin
`timescale 1ns/1ps
`include "sfx_consts.svh"
`define SFX_CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module sfx_synth_tb;
    localparam int CLICK = 20;
    localparam int BEEP  = 50;
    logic                  clk       = 1'b0;
    logic                  rst       = 1'b1;
    sfx_pkg::sfx_reg_req_t reg_req   = '0;
    logic signed [7:0]     pb_sample = 8'sh00;
    logic [15:0]           reg_rdata;
    logic                  audio_pwm;
    logic [8:0]            level;
    logic [15:0]           v;
    logic [7:0]            code;
    logic [7:0]            vol;
    int                    bad_count = 0;
    int                    samples_checked = 0;
    int                    n;

    always #10 clk = ~clk;

    sfx_synth #(.CLICK_CYCLES(CLICK), .BEEP_CYCLES(BEEP)) sfx_synth_inst (
        .clk(clk), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata),
        .pb_sample(pb_sample), .audio_pwm(audio_pwm));
    sfx_lpf_model sfx_lpf_model_inst (.clk(clk), .rst(rst), .pwm_in(audio_pwm), .level(level));

    // ====================
    // bus tasks
    task automatic wr(input logic [1:0] a, input logic [15:0] d);
        @(negedge clk);
        reg_req = '{wr: 1'b1, addr: a, data: d};
        @(negedge clk);
        reg_req.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [1:0] a, output logic [15:0] d);
        @(negedge clk);
        reg_req.addr = a;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd

    task automatic trig(input logic [15:0] sel);
        wr(`SFX_IDX_SOUND, sel);
        wr(`SFX_IDX_PLAY, 16'h0001);
    endtask : trig

    // counts cycles the play register reads 1, starting with the first read after the trigger
    task automatic count_play(input int cycles, output int cnt);
        cnt = 0;
        repeat (cycles)
        begin
            @(negedge clk);
            if (reg_rdata === 16'h0001) cnt++;
        end
    endtask : count_play

    function automatic logic [8:0] exp_duty(input logic signed [7:0] pb);
        return {1'b0, ~pb[7], pb[6:0]};
    endfunction : exp_duty

    // filtered level of the high half of a square effect at a given volume, no playback
    function automatic logic [8:0] exp_sq(input logic [7:0] vl);
        return 9'((int'(`SFX_SQ_HIGH) * int'(vl)) / 256 + int'(`SFX_PWM_OFFSET));
    endfunction : exp_sq

    task automatic conclude;
        $display("checked %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : conclude

    // ====================
    // main sequence
    initial
    begin
        void'($urandom(43014));
        repeat (16) @(negedge clk);
        rst = 1'b0;
        rd(`SFX_IDX_SOUND, v); `SFX_CHK(v, 16'h0000)
        rd(`SFX_IDX_PLAY, v); `SFX_CHK(v, 16'h0000)
        rd(`SFX_IDX_VOL, v); `SFX_CHK(v, 16'h00ff)
        rd(2'h3, v); `SFX_CHK(v, 16'h0000)
        repeat (300) @(negedge clk);
        `SFX_CHK(level, 9'h080)
        $display("test reset done");
        for (int i = 0; i < 5; i++)
        begin
            pb_sample = (i == 0) ? 8'sh80 : (i == 1) ? 8'sh7f : 8'($urandom);
            repeat (300) @(negedge clk);
            `SFX_CHK(level, exp_duty(pb_sample))
        end
        pb_sample = 8'sh00;
        $display("test mix done");
        trig({8'($urandom), `SFX_CODE_CLICK});
        count_play(100, n); `SFX_CHK(n, CLICK)
        trig({8'($urandom), `SFX_CODE_BEEP});
        count_play(100, n); `SFX_CHK(n, BEEP)
        wr(`SFX_IDX_PLAY, 16'h0000);
        count_play(20, n); `SFX_CHK(n, 0)
        trig(16'h0055);
        count_play(10, n); `SFX_CHK(n, 1)
        $display("test finite done");
        trig({8'h00, `SFX_CODE_BEEP});
        count_play(10, n);
        trig({8'h00, `SFX_CODE_CLICK});
        count_play(100, n); `SFX_CHK(n, CLICK)
        $display("test retrigger done");
        wr(`SFX_IDX_VOL, 16'h0000);
        rd(`SFX_IDX_VOL, v); `SFX_CHK(v, 16'h0000)
        for (int i = 0; i < 3; i++)
        begin
            code = (i == 0) ? `SFX_CODE_SINE : (i == 1) ? `SFX_CODE_SQUARE : `SFX_CODE_TRIANGLE;
            trig({8'($urandom), code});
            count_play(300, n); `SFX_CHK(n, 300)
            `SFX_CHK(level, 9'h080)
        end
        wr(`SFX_IDX_VOL, 16'h00ff);
        trig({8'($urandom), `SFX_CODE_SILENCE});
        count_play(300, n); `SFX_CHK(n, 0)
        `SFX_CHK(level, 9'h080)
        $display("test continuous done");
        vol = 8'($urandom);
        wr(`SFX_IDX_VOL, {8'h00, vol});
        trig({8'h00, `SFX_CODE_SQUARE});
        repeat (300) @(negedge clk);
        `SFX_CHK(level, exp_sq(vol))
        wr(`SFX_IDX_VOL, 16'h00ff);
        repeat (300) @(negedge clk);
        `SFX_CHK(level, exp_sq(8'hff))
        $display("test volume done");
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        rd(`SFX_IDX_PLAY, v); `SFX_CHK(v, 16'h0000)
        rd(`SFX_IDX_SOUND, v); `SFX_CHK(v, 16'h0000)
        repeat (300) @(negedge clk);
        `SFX_CHK(level, 9'h080)
        $display("test mid-run reset done");
        conclude();
    end
endmodule : sfx_synth_tb
